// File: logic/seq_pkg.sv
package seq_pkg;
    localparam int CLK_NS      = 10;
    localparam int DIR_FILT_NS = 1000;
    localparam int MON_FALL_NS = 1000;
    localparam int MON_RISE_NS = 5 * MON_FALL_NS;
    localparam int FCNT_W      = 10;
    localparam logic [FCNT_W-1:0] DIR_FILT_CYC =
        FCNT_W'((DIR_FILT_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [FCNT_W-1:0] MON_FALL_CYC =
        FCNT_W'((MON_FALL_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [FCNT_W-1:0] MON_RISE_CYC =
        FCNT_W'((MON_RISE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [2:0] GUARD_CYC = 3'h5;
    localparam int SYNC_W = 16;
    localparam int B_UP   = 4;
    localparam int B_DN   = 5;
    localparam int B_UD   = 6;
    localparam int B_FLT  = 7;
    localparam int B_LOCK = 8;
    localparam int B_COMB = 9;
    localparam int B_TMR  = 10;
    localparam int N_FILT = 8;

    typedef enum logic [3:0] {
        S_LOCK, S_SETF, S_CLRF, S_WOK, S_WAIT,
        S_DLY, S_EN, S_DONE, S_DIS
    } state_t;

    typedef struct packed {
        logic [3:0] step;
        logic       blank;
        logic       hold;
    } timer_t;
endpackage

// File: logic/quad_rail_up_down_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module quad_rail_up_down_sequencer
    import seq_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    input  wire logic       supply_lockout,
    input  wire logic       combined_mode,
    input  wire logic       up_request,
    input  wire logic       down_request,
    input  wire logic       updown_request,
    input  wire logic [3:0] rail_monitor,
    input  wire logic       fault_line_in,
    input  wire timer_t     timer_done,
    output var  logic [3:0] rail_enable,
    output var  logic       rails_good,
    output var  logic       sequence_complete,
    output var  logic       fault_line_out,
    output var  logic       fault_line_oe,
    output var  timer_t     timer_start
);

    function automatic logic [3:0] lower_mask(input logic [1:0] i);
        case (i)
            2'h0:    lower_mask = 4'h0;
            2'h1:    lower_mask = 4'h1;
            2'h2:    lower_mask = 4'h3;
            default: lower_mask = 4'h7;
        endcase
    endfunction

    function automatic logic [3:0] en_mask(input state_t s,
                                           input logic [1:0] i);
        case (s)
            S_DLY:   en_mask = lower_mask(i);
            S_EN:    en_mask = lower_mask(i) | (4'h1 << i);
            S_DONE:  en_mask = 4'hF;
            S_DIS:   en_mask = lower_mask(i);
            default: en_mask = 4'h0;
        endcase
    endfunction

    function automatic logic [FCNT_W-1:0] filt_len(input int i,
                                                   input logic rise);
        if (i < 4)
            filt_len = rise ? MON_RISE_CYC : MON_FALL_CYC;
        else
            filt_len = DIR_FILT_CYC;
    endfunction

    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [N_FILT-1:0] filt;
    logic [2:0]        dir_prev;
    state_t            state;
    state_t            next_state;
    logic [1:0]        idx;
    logic [1:0]        next_idx;
    timer_t            next_start;
    logic [2:0]        guard;
    logic              go_fault;

    wire logic [SYNC_W-1:0] raw = {timer_done, combined_mode,
        supply_lockout, fault_line_in, updown_request, down_request,
        up_request, rail_monitor};

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s1 <= '0;
            s2 <= '0;
        end else begin
            s1 <= raw;
            s2 <= s1;
        end
    end

    // Glitch filters: output follows input only after a stable run
    for (genvar g = 0; g < N_FILT; g++) begin : g_filt
        logic [FCNT_W-1:0] cnt;
        wire logic differ = s2[g] != filt[g];
        wire logic [FCNT_W-1:0] len = filt_len(g, s2[g]);
        always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
                cnt     <= '0;
                filt[g] <= 1'b0;
            end else if (!differ) begin
                cnt <= '0;
            end else if (cnt >= len - FCNT_W'(1)) begin
                cnt     <= '0;
                filt[g] <= s2[g];
            end else begin
                cnt <= cnt + FCNT_W'(1);
            end
        end
    end

    wire logic       lock    = s2[B_LOCK];
    wire logic       comb    = s2[B_COMB];
    wire timer_t     done_s  = s2[SYNC_W-1:B_TMR];
    wire logic [3:0] mon     = filt[3:0];
    wire logic       flt_hi  = filt[B_FLT];
    wire logic       up_f    = comb ? filt[B_UD] : filt[B_UP];
    wire logic       dn_f    = comb ? filt[B_UD] : filt[B_DN];
    wire logic       up_p    = comb ? dir_prev[2] : dir_prev[0];
    wire logic       dn_p    = comb ? dir_prev[2] : dir_prev[1];
    wire logic       up_rise = up_f & ~up_p;
    wire logic       dn_fall = ~dn_f & dn_p;
    wire logic       ext_flt = ~flt_hi & ~fault_line_oe;
    wire logic       uv_low  = |(~mon & lower_mask(idx));
    wire logic       sel_done =
        (state == S_SETF) ? done_s.hold :
        (state == S_EN)   ? done_s.blank : done_s.step[idx];
    wire logic       tdone   = sel_done && guard == 3'h0;
    wire logic       up_flt  = ext_flt | dn_fall | uv_low;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn)
            dir_prev <= 3'h0;
        else
            dir_prev <= filt[B_UD:B_UP];
    end

    always_comb begin
        next_state = state;
        next_idx   = idx;
        next_start = '0;
        go_fault   = 1'b0;
        case (state)
            S_LOCK: begin
                go_fault = 1'b1;
            end
            S_SETF: begin
                if (tdone)
                    next_state = S_CLRF;
            end
            S_CLRF: begin
                if (!up_f)
                    next_state = S_WOK;
            end
            S_WOK: begin
                if (flt_hi)
                    next_state = S_WAIT;
            end
            S_WAIT: begin
                if (ext_flt || dn_fall) begin
                    go_fault = 1'b1;
                end else if (up_rise) begin
                    next_idx = 2'h0;
                    if (comb) begin
                        next_state       = S_EN;
                        next_start.blank = 1'b1;
                    end else begin
                        next_state       = S_DLY;
                        next_start.step  = 4'h1;
                    end
                end
            end
            S_DLY: begin
                if (up_flt) begin
                    go_fault = 1'b1;
                end else if (tdone) begin
                    next_state       = S_EN;
                    next_start.blank = 1'b1;
                end
            end
            S_EN: begin
                if (up_flt) begin
                    go_fault = 1'b1;
                end else if (tdone) begin
                    if (!mon[idx]) begin
                        go_fault = 1'b1;
                    end else if (idx == 2'h3) begin
                        next_state = S_DONE;
                    end else begin
                        next_state      = S_DLY;
                        next_idx        = idx + 2'h1;
                        next_start.step = 4'h1 << (idx + 2'h1);
                    end
                end
            end
            S_DONE: begin
                if (ext_flt || up_rise || !(&mon)) begin
                    go_fault = 1'b1;
                end else if (dn_fall) begin
                    next_state      = S_DIS;
                    next_idx        = 2'h3;
                    next_start.step = 4'h8;
                end
            end
            S_DIS: begin
                if (ext_flt || up_rise || uv_low) begin
                    go_fault = 1'b1;
                end else if (idx == 2'h0 && comb) begin
                    next_state = S_WAIT;
                end else if (tdone) begin
                    if (idx == 2'h0) begin
                        next_state = S_WAIT;
                    end else begin
                        next_idx = idx - 2'h1;
                        // Combined variant has no first delay timer to arm
                        if (!(comb && idx == 2'h1))
                            next_start.step = 4'h1 << (idx - 2'h1);
                    end
                end
            end
            default: begin
                go_fault = 1'b1;
            end
        endcase
        if (go_fault) begin
            next_state      = S_SETF;
            next_idx        = 2'h0;
            next_start      = '0;
            next_start.hold = 1'b1;
        end
        if (lock) begin
            next_state = S_LOCK;
            next_idx   = 2'h0;
            next_start = '0;
        end
    end

    // Guard hides a stale done level while the timer re-arms
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn)
            guard <= GUARD_CYC;
        else if (|next_start)
            guard <= GUARD_CYC;
        else if (guard != 3'h0)
            guard <= guard - 3'h1;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state <= S_LOCK;
            idx   <= 2'h0;
        end else begin
            state <= next_state;
            idx   <= next_idx;
        end
    end

    wire logic next_seq = next_state == S_DONE || next_state == S_DIS;
    wire logic next_oe  = next_state == S_LOCK || next_state == S_SETF
                          || next_state == S_CLRF;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rail_enable       <= 4'h0;
            rails_good        <= 1'b0;
            sequence_complete <= 1'b0;
            fault_line_out    <= 1'b0;
            fault_line_oe     <= 1'b1;
            timer_start       <= '0;
        end else begin
            rail_enable       <= en_mask(next_state, next_idx);
            rails_good        <= &mon & ~lock;
            sequence_complete <= next_seq;
            fault_line_out    <= 1'b0;
            fault_line_oe     <= next_oe;
            timer_start       <= next_start;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    a_lock_outputs: assert property (
        state == S_LOCK |-> rail_enable == 4'h0 && !sequence_complete
            && fault_line_oe && !rails_good)
        else $error("outputs not held low in lockout");
    a_lock_release: assert property (
        state == S_LOCK && !lock |=> state == S_SETF && timer_start.hold)
        else $error("lockout release did not enter set-fault");
    a_clear_holds: assert property (
        state == S_CLRF && up_f && !lock |=> state == S_CLRF && fault_line_oe)
        else $error("clear-fault left while up high");
    a_wait_idle: assert property (
        state == S_WAIT && !up_rise && !dn_fall && !ext_flt && !lock
            |=> state == S_WAIT)
        else $error("wait-start left without cause");
    a_start_path: assert property (
        state == S_WAIT && up_rise && !dn_fall && !ext_flt && !lock
            |=> state == (comb ? S_EN : S_DLY) && idx == 2'h0)
        else $error("start edge took wrong path");
    a_blank_fail: assert property (
        state == S_EN && tdone && !mon[idx] && !up_flt && !lock
            |=> state == S_SETF ##1 rail_enable == 4'h0)
        else $error("rail low at blanking end not faulted");
    a_down_fault: assert property (
        (state == S_WAIT || state == S_DLY || state == S_EN) && dn_fall
            && !lock |=> state == S_SETF)
        else $error("down falling edge not faulted");
    a_good_and: assert property (
        !lock |=> rails_good == $past(&mon))
        else $error("rails good not the AND of monitors");
    a_done_out: assert property (
        state == S_DONE |-> rail_enable == 4'hF && sequence_complete)
        else $error("done state outputs wrong");
    a_up_rise_dis: assert property (
        state == S_DIS && up_rise && !lock |=> state == S_SETF)
        else $error("up rise in power-down not faulted");
    a_setf_outputs: assert property (
        state == S_SETF |-> rail_enable == 4'h0 && !sequence_complete
            && fault_line_oe)
        else $error("set-fault outputs wrong");

    c_power_up: cover property (state == S_EN ##1 state == S_DONE);
    c_power_down: cover property (state == S_DIS ##1 state == S_WAIT);
    c_blank_fault: cover property (state == S_EN ##1 state == S_SETF);

endmodule
`default_nettype wire

// File: sim/rail_partner.sv
`timescale 1ns/1ps
`default_nettype none
module rail_partner
    import seq_pkg::*;
#(
    parameter int STEP  = 50,
    parameter int BLANK = 700
)(
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    input  wire logic       slow,
    input  wire logic [3:0] fail_mask,
    input  wire logic [3:0] rail_enable,
    input  wire timer_t     timer_start,
    output var  logic [3:0] rail_monitor,
    output var  timer_t     timer_done
);
    int         cnt [6];
    int         ramp [4];
    logic [5:0] go;
    logic [5:0] fin;

    assign go = timer_start;
    assign timer_done = timer_t'(fin);

    function automatic int lim(input int i);
        return (slow ? 2 : 1) * (i == 1 ? BLANK : STEP);
    endfunction

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            fin <= '0;
            cnt <= '{default: 0};
            ramp <= '{default: 0};
            rail_monitor <= '0;
        end else begin
            // Done stays high until the timer is started again
            for (int i = 0; i < 6; i++) begin
                if (go[i]) begin
                    fin[i] <= 1'b0;
                    cnt[i] <= 0;
                end else if (cnt[i] < lim(i)) begin
                    cnt[i] <= cnt[i] + 1;
                end else begin
                    fin[i] <= 1'b1;
                end
            end
            // Regulators ramp up, collapse at once when off or failed
            for (int i = 0; i < 4; i++) begin
                ramp[i] <= (rail_enable[i] && !fail_mask[i]) ? ramp[i] + 1 : 0;
                rail_monitor[i] <= ramp[i] > (slow ? 40 : 10);
            end
        end
    end
endmodule
`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import seq_pkg::*;
;
    typedef struct packed {
        logic comb;
        logic slw;
        logic st0;
    } row_t;
    logic       clk_sys = 1'b0;
    logic       rstn = 1'b0;
    logic       supply_lockout = 1'b0;
    logic       combined_mode = 1'b0;
    logic       up_request = 1'b0;
    logic       down_request = 1'b1;
    logic       updown_request = 1'b0;
    logic       slow = 1'b0;
    logic       ext_pull = 1'b0;
    logic [3:0] fail_mask = 4'h0;
    logic       st0 = 1'b0;
    logic       hld = 1'b0;
    logic [3:0] rail_monitor;
    logic [3:0] rail_enable;
    logic       rails_good;
    logic       sequence_complete;
    logic       fault_line_in;
    logic       fault_line_out;
    logic       fault_line_oe;
    timer_t     timer_done;
    timer_t     timer_start;
    int         fail_count = 0;
    int         tests_run = 0;
    time        t_rel;
    row_t       rows [4] = '{3'b001, 3'b011, 3'b100, 3'b110};

    always #5 clk_sys = ~clk_sys;
    // Shared open-drain line with pull-up
    assign fault_line_in = (fault_line_oe ? fault_line_out : 1'b1) & !ext_pull;

    quad_rail_up_down_sequencer DUT (
        .clk_sys(clk_sys), .rstn(rstn), .supply_lockout(supply_lockout),
        .combined_mode(combined_mode), .up_request(up_request),
        .down_request(down_request), .updown_request(updown_request),
        .rail_monitor(rail_monitor), .fault_line_in(fault_line_in),
        .timer_done(timer_done), .rail_enable(rail_enable),
        .rails_good(rails_good), .sequence_complete(sequence_complete),
        .fault_line_out(fault_line_out), .fault_line_oe(fault_line_oe),
        .timer_start(timer_start));
    rail_partner far_side (
        .clk_sys(clk_sys), .rstn(rstn), .slow(slow), .fail_mask(fail_mask),
        .rail_enable(rail_enable), .timer_start(timer_start),
        .rail_monitor(rail_monitor), .timer_done(timer_done));

    always @(posedge clk_sys) begin
        if (timer_start.step[0]) st0 <= 1'b1;
        if (timer_start.hold) hld <= 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic report_and_stop;
        $display("checks %0d errors %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [3:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    function automatic logic [3:0] peek(input int sel);
        case (sel)
            0: return rail_enable;
            1: return {3'h0, fault_line_oe};
            default: return {3'h0, sequence_complete};
        endcase
    endfunction

    task automatic wait_for(input int sel, input logic [3:0] e, input int b);
        int n;
        n = 0;
        while (peek(sel) !== e && n < b) begin
            tick(1);
            n++;
        end
        if (n >= b) begin
            fail_count++;
            $display("wrong value wait %0d expected %h seen %h", sel, e,
                     peek(sel));
            report_and_stop();
        end
    endtask

    task automatic do_up;
        logic [3:0] e;
        e = 4'h0;
        up_request = !combined_mode;
        updown_request = combined_mode;
        for (int k = 0; k < 4; k++) begin
            e = {e[2:0], 1'b1};
            wait_for(0, e, 5000);
            check("rails", rail_enable, e);
        end
        wait_for(2, 4'h1, 5000);
        check("done", {3'h0, sequence_complete}, 4'h1);
    endtask

    task automatic do_down;
        logic [3:0] e;
        e = 4'hF;
        down_request = combined_mode;
        updown_request = 1'b0;
        for (int k = 0; k < 4; k++) begin
            e = e >> 1;
            wait_for(0, e, 500);
            check("rails", rail_enable, e);
        end
        wait_for(2, 4'h0, 500);
        check("done", {3'h0, sequence_complete}, 4'h0);
        down_request = 1'b1;
        up_request = 1'b0;
        tick(150);
    endtask

    task automatic fault;
        wait_for(1, 4'h1, 5000);
        tick(2);
        check("rails", rail_enable, 4'h0);
        check("done", {3'h0, sequence_complete}, 4'h0);
        check("fout", {3'h0, fault_line_out}, 4'h0);
        fail_mask = 4'h0;
        up_request = 1'b0;
        down_request = 1'b1;
        wait_for(1, 4'h0, 3000);
        tick(300);
    endtask

    initial begin
        tick(20);
        check("oe", {3'h0, fault_line_oe}, 4'h1);
        rstn = 1'b1;
        t_rel = $time;
        wait_for(1, 4'h0, 3000);
        tick(200);
        foreach (rows[i]) begin
            combined_mode = rows[i].comb;
            slow = rows[i].slw;
            while (rows[i].comb && $time < t_rel + 500000) begin
                tick(1);
            end
            tick(150);
            st0 = 1'b0;
            do_up();
            check("st0", {3'h0, st0}, {3'h0, rows[i].st0});
            tick(10);
            check("good", {3'h0, rails_good}, 4'h1);
            st0 = 1'b0;
            do_down();
            check("st0", {3'h0, st0}, {3'h0, rows[i].st0});
            check("good", {3'h0, rails_good}, 4'h0);
        end
        combined_mode = 1'b0;
        slow = 1'b0;
        tick(200);
        // Short pulse on the start input must be swallowed
        up_request = 1'b1;
        tick(30);
        up_request = 1'b0;
        tick(300);
        check("rails", rail_enable, 4'h0);
        check("oe", {3'h0, fault_line_oe}, 4'h0);
        down_request = 1'b0;
        fault();
        fail_mask = 4'h4;
        up_request = 1'b1;
        wait_for(0, 4'h7, 5000);
        fault();
        up_request = 1'b1;
        wait_for(0, 4'h3, 5000);
        fail_mask = 4'h1;
        fault();
        do_up();
        up_request = 1'b0;
        tick(150);
        check("done", {3'h0, sequence_complete}, 4'h1);
        up_request = 1'b1;
        fault();
        do_up();
        up_request = 1'b0;
        tick(150);
        down_request = 1'b0;
        wait_for(0, 4'h3, 2000);
        up_request = 1'b1;
        fault();
        do_up();
        down_request = 1'b0;
        wait_for(0, 4'h7, 2000);
        fail_mask = 4'h1;
        fault();
        do_up();
        ext_pull = 1'b1;
        fault();
        up_request = 1'b1;
        tick(300);
        check("rails", rail_enable, 4'h0);
        up_request = 1'b0;
        tick(150);
        ext_pull = 1'b0;
        tick(300);
        do_up();
        supply_lockout = 1'b1;
        tick(10);
        check("rails", rail_enable, 4'h0);
        check("good", {3'h0, rails_good}, 4'h0);
        check("done", {3'h0, sequence_complete}, 4'h0);
        up_request = 1'b0;
        tick(150);
        hld = 1'b0;
        supply_lockout = 1'b0;
        wait_for(1, 4'h0, 3000);
        check("hold", {3'h0, hld}, 4'h1);
        report_and_stop();
    end
endmodule
`default_nettype wire
